// [inc/acpm_pkg.sv]
// Package for the converter control pin decoder: register map, field layout, types
package acpm_pkg;
	localparam int         DATA_W        = 12;
	localparam int         SREG_W        = 16;
	localparam int         SADDR_W       = 4;
	localparam int         SADDR_LSB     = 12;
	localparam int         SERIAL_WRITE_DATA_W       = 12;
	localparam int         NUM_SREG      = 16;
	localparam logic [3:0] SREG_CTRL     = 4'h0;
	localparam int         CTRL_INV_BIT  = 0;
	localparam int         CTRL_OEA_BIT  = 1;
	localparam int         CTRL_PD_BIT   = 2;
	localparam logic [11:0] SREG_RESET   = 12'h000;
	localparam logic [11:0] TOP_BIT_MASK = 12'h800;

	// AXI4-Lite register byte addresses
	localparam logic [7:0] ADDR_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_IRQ      = 8'h04;
	localparam logic [7:0] ADDR_MASK     = 8'h08;
	localparam logic [7:0] ADDR_CTRL_RB  = 8'h0C;
	localparam logic [7:0] ADDR_SREG_RB  = 8'h10;
	localparam logic [1:0] RESP_OKAY     = 2'b00;
	localparam logic [1:0] RESP_SLVERR   = 2'b10;

	// Status/interrupt bits
	localparam int         IRQ_W         = 4;
	localparam int         IRQ_OVER_RANGE_FLAG_A     = 0;
	localparam int         IRQ_OVER_RANGE_FLAG_B     = 1;
	localparam int         IRQ_SWRITE    = 2;
	localparam int         IRQ_SRESET    = 3;

	typedef struct packed {
		logic       sel;
		logic       pin41;
		logic       pin42;
		logic       pin45;
		logic       oe_b_n;
	} acpm_pins_type;

	typedef struct packed {
		logic       invert;
		logic       oe_a_n;
		logic       standby;
	} acpm_ctrl_type;
endpackage

// [logic/acpm_top.sv]
// Shared control pin decoder, serial write port and AXI4-Lite status of a dual converter
`timescale 1ns/1ps
module acpm_top
	import acpm_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire acpm_pkg::acpm_pins_type     pins,
	input  wire logic [acpm_pkg::DATA_W-1:0] conv_a,
	input  wire logic [acpm_pkg::DATA_W-1:0] conv_b,
	input  wire logic                        range_a,
	input  wire logic                        range_b,
	output logic      [acpm_pkg::DATA_W-1:0] dout_a,
	output logic      [acpm_pkg::DATA_W-1:0] dout_a_oe,
	output logic      [acpm_pkg::DATA_W-1:0] dout_b,
	output logic      [acpm_pkg::DATA_W-1:0] dout_b_oe,
	output logic                             over_range_flag_a,
	output logic                             over_range_flag_b,
	output logic                             standby_control,
	output logic                             irq,
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic      [31:0]                 s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	import acpm_pkg::*;

	// Offset binary to two's complement is a flip of the top bit only
	function automatic logic [DATA_W-1:0] code_fmt(
		input logic [DATA_W-1:0] raw,
		input logic              inv
	);
		return inv ? (raw ^ TOP_BIT_MASK) : raw;
	endfunction

	// Only the status clear and mask registers accept writes
	function automatic logic wr_mapped(input logic [7:0] a);
		return (a == ADDR_IRQ) || (a == ADDR_MASK);
	endfunction

	// Pins come from another domain: two-stage synchronisers
	acpm_pins_type pins_m_q;
	acpm_pins_type pins_s_q;
	acpm_pins_type pins_p_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_m_q <= '0;
			pins_s_q <= '0;
			pins_p_q <= '0;
		end else begin
			pins_m_q <= pins;
			pins_s_q <= pins_m_q;
			pins_p_q <= pins_s_q;
		end
	end

	logic serial_mode;
	logic top_bit_invert;
	logic serial_write_strobe;
	logic serial_write_clock;
	logic serial_write_data;
	assign serial_mode = pins_s_q.sel;
	assign top_bit_invert = pins_s_q.pin41;
	assign serial_write_strobe = pins_s_q.pin41;
	assign serial_write_clock = pins_s_q.pin42;
	assign serial_write_data = pins_s_q.pin45;

	// Serial shift register; strobe low frames a word, clock rising shifts
	logic [SREG_W-1:0]  shift_q;
	logic [4:0]         bitcnt_q;
	logic [SERIAL_WRITE_DATA_W-1:0] sreg_q [NUM_SREG];
	logic               sclk_rise;
	logic               word_done;
	logic               sel_fall;
	assign sclk_rise = serial_mode && serial_write_clock && !pins_p_q.pin42;
	assign word_done = sclk_rise && !serial_write_strobe && (bitcnt_q == 5'(SREG_W - 1));
	assign sel_fall  = pins_p_q.sel && !pins_s_q.sel;

	always_ff @(posedge aclk) begin
		if (!aresetn || !serial_mode || serial_write_strobe) begin
			shift_q  <= '0;
			bitcnt_q <= '0;
		end else if (sclk_rise) begin
			shift_q  <= {shift_q[SREG_W-2:0], serial_write_data};
			bitcnt_q <= word_done ? 5'd0 : bitcnt_q + 5'd1;
		end
	end

	logic [SREG_W-1:0] word_full;
	assign word_full = {shift_q[SREG_W-2:0], serial_write_data};

	// Registers written only by a full serial word; select low resets them
	always_ff @(posedge aclk) begin
		if (!aresetn || !serial_mode) begin
			for (int i = 0; i < NUM_SREG; i++) begin
				sreg_q[i] <= SREG_RESET;
			end
		end else if (word_done) begin
			sreg_q[word_full[SADDR_LSB +: SADDR_W]] <= word_full[SERIAL_WRITE_DATA_W-1:0];
		end
	end

	// Control selection: parallel pins, or the serial control register contents
	acpm_ctrl_type ctrl;
	always_comb begin
		if (!serial_mode) begin
			ctrl.invert  = top_bit_invert;
			ctrl.oe_a_n  = pins_s_q.pin42;
			ctrl.standby = pins_s_q.pin45;
		end else begin
			ctrl.invert  = sreg_q[SREG_CTRL][CTRL_INV_BIT];
			ctrl.oe_a_n  = sreg_q[SREG_CTRL][CTRL_OEA_BIT];
			ctrl.standby = sreg_q[SREG_CTRL][CTRL_PD_BIT];
		end
	end

	// Data path registers; invert of top bit converts offset to two's complement
	logic [DATA_W-1:0] dout_a_q;
	logic [DATA_W-1:0] dout_b_q;
	logic              oe_a_q;
	logic              oe_b_q;
	logic              standby_q;
	logic              over_range_flag_a_q;
	logic              over_range_flag_b_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dout_a_q  <= '0;
			dout_b_q  <= '0;
			oe_a_q    <= 1'b0;
			oe_b_q    <= 1'b0;
			standby_q <= 1'b0;
			over_range_flag_a_q   <= 1'b0;
			over_range_flag_b_q   <= 1'b0;
		end else begin
			dout_a_q  <= code_fmt(conv_a, ctrl.invert);
			dout_b_q  <= code_fmt(conv_b, ctrl.invert);
			oe_a_q    <= !ctrl.oe_a_n && !ctrl.standby;
			oe_b_q    <= !pins_s_q.oe_b_n && !ctrl.standby;
			standby_q <= ctrl.standby;
			over_range_flag_a_q   <= range_a && !ctrl.standby;
			over_range_flag_b_q   <= range_b && !ctrl.standby;
		end
	end
	assign dout_a            = dout_a_q;
	assign dout_b            = dout_b_q;
	assign dout_a_oe         = {DATA_W{oe_a_q}};
	assign dout_b_oe         = {DATA_W{oe_b_q}};
	assign over_range_flag_a = over_range_flag_a_q;
	assign over_range_flag_b = over_range_flag_b_q;
	assign standby_control   = standby_q;

	// AXI4-Lite write: address and data taken in either order
	logic              aw_got_q;
	logic              w_got_q;
	logic [7:0]        awaddr_q;
	logic [31:0]       wdata_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic [IRQ_W-1:0]  irq_q;
	logic [IRQ_W-1:0]  mask_q;
	logic              wr_fire;
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready  = !w_got_q && !bvalid_q;
	assign wr_fire       = aw_got_q && w_got_q && !bvalid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= '0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// Sticky events; a set in the clearing cycle wins
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] clr;
	assign events = {sel_fall, word_done, over_range_flag_b_q, over_range_flag_a_q};
	assign clr = (wr_fire && awaddr_q == ADDR_IRQ) ? wdata_q[IRQ_W-1:0] : '0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q  <= '0;
			mask_q <= '0;
		end else begin
			irq_q <= (irq_q & ~clr) | events;
			if (wr_fire && awaddr_q == ADDR_MASK) begin
				mask_q <= wdata_q[IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irq_q & mask_q);

	// AXI4-Lite read
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	assign s_axi_arready = !rvalid_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_STATUS:  rdata_q <= {27'h000_0000, serial_mode, standby_q,
					oe_b_q, oe_a_q, ctrl.invert};
				ADDR_IRQ:     rdata_q <= {28'h000_0000, irq_q};
				ADDR_MASK:    rdata_q <= {28'h000_0000, mask_q};
				ADDR_CTRL_RB: rdata_q <= {20'h0_0000, sreg_q[SREG_CTRL]};
				ADDR_SREG_RB: rdata_q <= {16'h0000, shift_q};
				default: begin
					rdata_q <= '0;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	AST_PARALLEL_INVERT: assert property (@(posedge aclk) disable iff (!aresetn)
		!serial_mode |=> dout_a == ($past(pins_s_q.pin41) ? ($past(conv_a) ^ TOP_BIT_MASK)
		: $past(conv_a)))
		else $error("channel A code format wrong");
	AST_OEA: assert property (@(posedge aclk) disable iff (!aresetn)
		(!serial_mode && pins_s_q.pin42) |=> dout_a_oe == '0)
		else $error("channel A driven while disabled");
	AST_OEB: assert property (@(posedge aclk) disable iff (!aresetn)
		pins_s_q.oe_b_n |=> dout_b_oe == '0)
		else $error("channel B driven while disabled");
	AST_STANDBY: assert property (@(posedge aclk) disable iff (!aresetn)
		(!serial_mode && pins_s_q.pin45) |=> standby_control)
		else $error("standby not entered");
	AST_OVER_RANGE_FLAG_A: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl.standby |=> over_range_flag_a == $past(range_a))
		else $error("channel A over-range flag wrong");
	AST_OVER_RANGE_FLAG_B: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl.standby |=> over_range_flag_b == $past(range_b))
		else $error("channel B over-range flag wrong");
	AST_OEA_ON: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ctrl.oe_a_n && !ctrl.standby) |=> dout_a_oe == '1)
		else $error("channel A not driven while enabled");
	AST_OEB_ON: assert property (@(posedge aclk) disable iff (!aresetn)
		(!pins_s_q.oe_b_n && !ctrl.standby) |=> dout_b_oe == '1)
		else $error("channel B not driven while enabled");
	AST_PARALLEL_NO_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
		!serial_mode |=> bitcnt_q == '0 && !word_done)
		else $error("serial port active in parallel mode");
	AST_SERIAL_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
		!serial_mode |=> sreg_q[SREG_CTRL] == SREG_RESET)
		else $error("serial registers not reset");
	AST_SERIAL_DEFAULT: assert property (@(posedge aclk) disable iff (!aresetn)
		($rose(serial_mode)) |-> !ctrl.invert && !ctrl.oe_a_n && !ctrl.standby)
		else $error("serial mode controls not default");
	AST_SHIFT_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
		(serial_mode && sclk_rise && !serial_write_strobe && bitcnt_q < 5'(SREG_W - 1)) |=>
		bitcnt_q == $past(bitcnt_q) + 5'd1)
		else $error("serial bit not counted");
	AST_WRITE_SOURCE: assert property (@(posedge aclk) disable iff (!aresetn)
		(serial_mode && !word_done) |=> $stable(sreg_q[SREG_CTRL]) || !serial_mode)
		else $error("register changed without a serial word");

	// Serial port checks
	AST_STROBE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
		serial_write_strobe |=> bitcnt_q == '0)
		else $error("shift count kept while strobe idle");
	AST_SERIAL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		(word_done && word_full[SADDR_LSB +: SADDR_W] == SREG_CTRL) |=>
		sreg_q[SREG_CTRL] == $past(word_full[SERIAL_WRITE_DATA_W-1:0]))
		else $error("serial word not stored");
	AST_SERIAL_INVERT: assert property (@(posedge aclk) disable iff (!aresetn)
		serial_mode |=> dout_a == ($past(sreg_q[SREG_CTRL][CTRL_INV_BIT])
		? ($past(conv_a) ^ TOP_BIT_MASK) : $past(conv_a)))
		else $error("channel A code format wrong in serial mode");
	AST_SERIAL_OEA: assert property (@(posedge aclk) disable iff (!aresetn)
		(serial_mode && sreg_q[SREG_CTRL][CTRL_OEA_BIT]) |=> dout_a_oe == '0)
		else $error("channel A driven while serially disabled");

	// Register bus answers stand until taken; a new event always lands
	AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_RVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_IRQ_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		(|events) |=> (irq_q & $past(events)) == $past(events))
		else $error("event lost in status");
	COV_SERIAL_WORD: cover property (@(posedge aclk) disable iff (!aresetn) word_done);
	COV_PARALLEL_OFF: cover property (@(posedge aclk) disable iff (!aresetn)
		!serial_mode && dout_a_oe == '0);
	COV_SEL_PULSE: cover property (@(posedge aclk) disable iff (!aresetn) sel_fall);
	COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) irq);
	COV_STANDBY: cover property (@(posedge aclk) disable iff (!aresetn) standby_control);
endmodule

// [tb/acpm_host.sv]
// Host model that drives the shared control pins of the converter
`timescale 1ns/1ps
module acpm_host
	import acpm_pkg::*;
(
	output acpm_pkg::acpm_pins_type pins
);
	logic aclk;
	assign aclk = tb.aclk;
	initial pins = '0;
	task automatic hold(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// v = {invert, chan A off, standby, chan B off}
	task automatic set_static(input logic [3:0] v);
		@(posedge aclk);
		pins <= {1'b0, v};
	endtask
	// Select low then high; leaves the port idle with strobe high
	task automatic sel_pulse();
		@(posedge aclk);
		pins <= '0;
		hold(6);
		pins <= 5'b1_1000;
		hold(6);
	endtask
	// Six aclk per phase keeps each phase past the two-flop synchroniser
	task automatic swrite(input logic [15:0] w);
		@(posedge aclk);
		pins.pin41 <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			pins.pin45 <= w[i];
			hold(6);
			pins.pin42 <= 1'b1;
			hold(6);
			pins.pin42 <= 1'b0;
		end
		hold(6);
		pins.pin41 <= 1'b1;
		// Released data line must not keep the last bit
		pins.pin45 <= ~w[0];
		hold(6);
	endtask
endmodule

// [tb/tb.sv]
// Testbench for the converter control pin decoder
`timescale 1ns/1ps
module tb;
	import acpm_pkg::*;
	logic aclk, aresetn, range_a, range_b, over_range_flag_a, over_range_flag_b;
	logic standby_control, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	acpm_pins_type pins;
	logic [11:0] conv_a, conv_b, dout_a, dout_a_oe, dout_b, dout_b_oe, ea;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, c;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int bad_count, samples_checked;
	acpm_host u_acpm_host (.pins(pins));
	acpm_top u_acpm_top (.aclk, .aresetn, .pins, .conv_a, .conv_b, .range_a, .range_b,
		.dout_a, .dout_a_oe, .dout_b, .dout_b_oe, .over_range_flag_a, .over_range_flag_b,
		.standby_control, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_wstrb <= 4'hF;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wstrb <= 4'h0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, d, e);
		chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		test_done();
	end
	initial begin
		{aresetn, range_a, range_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h0;
		conv_a = 12'h123;
		conv_b = 12'h456;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rchk("status", ADDR_STATUS, 32'h0000_0006);
		chk("oe_a", dout_a_oe, 12'hFFF);
		chk("stby", standby_control, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			c = 4'b1000 >> i;
			range_a <= i[0];
			range_b <= ~i[0];
			conv_a <= {~i[3:0], 8'h23};
			conv_b <= {8'h45, i[3:0]};
			u_acpm_host.set_static(c);
			u_acpm_host.hold(6);
			ea = c[3] ? 12'h800 : 12'h000;
			if (!c[1]) chk("dout_a", dout_a, conv_a ^ ea);
			if (!c[1]) chk("dout_b", dout_b, conv_b ^ ea);
			chk("oe_a", dout_a_oe, (c[2] | c[1]) ? 12'h000 : 12'hFFF);
			chk("oe_b", dout_b_oe, (c[0] | c[1]) ? 12'h000 : 12'hFFF);
			chk("stby", standby_control, c[1]);
			chk("over_range_flag_a", over_range_flag_a, i[0] & !c[1]);
			chk("over_range_flag_b", over_range_flag_b, !i[0] & !c[1]);
			rchk("status", ADDR_STATUS,
				{27'h0, 1'b0, c[1], !(c[0] | c[1]), !(c[2] | c[1]), c[3]});
		end
		$display("test parallel pins done");
		range_a <= 1'b0;
		range_b <= 1'b0;
		u_acpm_host.set_static(4'h0);
		u_acpm_host.hold(4);
		wr(ADDR_IRQ, 32'h0000_000F);
		rchk("irq_st", ADDR_IRQ, 32'h0000_0000);
		range_a <= 1'b1;
		u_acpm_host.hold(1);
		range_a <= 1'b0;
		u_acpm_host.hold(4);
		rchk("irq_st", ADDR_IRQ, 32'h0000_0001);
		chk("irq_masked", irq, 1'b0);
		wr(ADDR_MASK, 32'h0000_0001);
		rchk("mask", ADDR_MASK, 32'h0000_0001);
		chk("irq_on", irq, 1'b1);
		wr(ADDR_IRQ, 32'h0000_0001);
		u_acpm_host.hold(2);
		chk("irq_off", irq, 1'b0);
		rd(8'h20);
		chk("bad_rd", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
		wr(8'h20, 32'h0000_0007);
		chk("bad_wr", r, RESP_SLVERR);
		$display("test irq and bus done");
		u_acpm_host.sel_pulse();
		// Strobe idle high would read as invert in parallel mode
		chk("dout_a", dout_a, conv_a);
		rchk("status", ADDR_STATUS, 32'h0000_0016);
		u_acpm_host.swrite(16'h0001);
		rchk("ctrl_rb", ADDR_CTRL_RB, 32'h0000_0001);
		chk("dout_a", dout_a, conv_a ^ 12'h800);
		rd(ADDR_IRQ);
		chk("irq_sw", d[2], 1'b1);
		rchk("sreg_rb", ADDR_SREG_RB, 32'h0000_0000);
		u_acpm_host.swrite(16'h1007);
		rchk("ctrl_rb", ADDR_CTRL_RB, 32'h0000_0001);
		u_acpm_host.swrite(16'h0002);
		chk("oe_a", dout_a_oe, 12'h000);
		chk("oe_b", dout_b_oe, 12'hFFF);
		chk("dout_a", dout_a, conv_a);
		u_acpm_host.swrite(16'h0004);
		chk("stby", standby_control, 1'b1);
		u_acpm_host.sel_pulse();
		rchk("ctrl_rb", ADDR_CTRL_RB, 32'h0000_0000);
		chk("stby", standby_control, 1'b0);
		rd(ADDR_IRQ);
		chk("irq_sel", d[3], 1'b1);
		$display("test serial port done");
		test_done();
	end
endmodule
